// ==== src/eep_mem.sv ====
module eep_mem #(
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter int DW = 8
) (
    // clock
    input wire logic clk_sys,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // registered read port
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    // ==========================================================
    // storage; no reset, contents survive a logic reset
    logic [DW-1:0] mem_r [DEPTH];
    logic [DW-1:0] rdata_r;

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (re) begin
            rdata_r <= mem_r[raddr];
        end
    end

    assign rdata = rdata_r;

endmodule

// ==== src/eep_pkg.sv ====
package eep_pkg;

    // ==========================================================
    // timing
    localparam int SYS_CLK_KHZ = 100000;
    localparam int T_WR_MS = 3;
    // longest write cycle time in clock cycles, exactly 300000 at this clock
    localparam int T_WR_CYC = T_WR_MS * SYS_CLK_KHZ;

    // ==========================================================
    // array organisation
    localparam int ADDR_W = 13;
    localparam int ARRAY_BYTES = 8192;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_OFS_W = 5;
    localparam int MEM_AW = 14;
    localparam int MEM_DEPTH = ARRAY_BYTES + PAGE_BYTES;
    localparam logic [MEM_AW-1:0] ID_PAGE_BASE = 14'h2000;

    // ==========================================================
    // device address word and command fields
    localparam logic [3:0] TYPE_ARRAY = 4'hA;
    localparam logic [3:0] TYPE_ID_PAGE = 4'hB;
    localparam int DEVADDR_TYPE_LSB = 4;
    localparam int DEVADDR_CS_LSB = 1;
    localparam int DEVADDR_RW_BIT = 0;
    localparam int ID_LOCK_SEL_BIT = 10;
    localparam int ID_LOCK_DATA_BIT = 1;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // ==========================================================
    // reset values
    localparam logic [5:0] PINS_RESET = 6'h30;

    // ==========================================================
    // types
    typedef struct packed {
        logic scl;
        logic sda;
        logic [2:0] cs;
        logic wp;
    } eep_pins_t;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_DEVADDR = 7'h02,
        ST_ADDR_HI = 7'h04,
        ST_ADDR_LO = 7'h08,
        ST_WDATA   = 7'h10,
        ST_RDATA   = 7'h20,
        ST_WCYCLE  = 7'h40
    } eep_state_t;

endpackage

// ==== src/eep_sync.sv ====
module eep_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // levels from outside the clock domain
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // two-stage synchroniser; the first stage feeds only the second
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_r <= RESET_VAL;
            sync_r <= RESET_VAL;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

// ==== src/eep_top.sv ====
// Notes on behaviour
// - after a start the master sends type, three select bits, then read/write bit
// - the select bits must equal the three hardwired select inputs
// - a floating select input counts as low
// - read/write bit one starts a read, zero starts a write
// - matching address is acknowledged; mismatch goes to standby until next start
// - data changes only while clock low; changes while high are start or stop
// - data falling while clock high is a start; every command begins with one
// - data rising while clock high is a stop; stop after read gives standby
// - bytes are eight bits; device drives zero in the ninth clock as acknowledge
// - incoming data sampled on clock rise, outgoing data changed after clock fall
// - standby at power-up, and after stop once internal work has finished
// - array is 256 pages of 32 bytes, 13-bit word address
// - byte write: address word, two address bytes, one data byte, stop, timed write
// - during the internal write cycle bus inputs are ignored and nothing is answered
// - page write sends up to 32 bytes before the stop, each acknowledged
// - page write increments only the low five address bits, wrapping in the page
// - write-protect high protects the whole array against writes
// - id page write uses type 1011b, select bit zero, low bits pick the byte
// - locked id page: data bytes of an id page write are not acknowledged
// - polling during the write cycle is acknowledged only after it completes
// - data line is driven only low, released for high
// - lock command: type 1011b, select bit one, data bit 1 set, locks the id page
// - address counter holds last address plus one for reads without an address
module eep_top #(
    parameter int T_WR_CYC = eep_pkg::T_WR_CYC
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // two-wire link
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // hardwired straps
    input wire logic chip_select_bit_2,
    input wire logic chip_select_bit_1,
    input wire logic chip_select_bit_0,
    input wire logic write_protect,
    // status
    output logic busy,
    output logic standby,
    output logic id_page_locked
);

    localparam int WC_W = $clog2(T_WR_CYC);

    // ==========================================================
    // link domain: data bit captured on the serial clock rise
    logic scl_bit_r;

    always_ff @(posedge scl) begin
        scl_bit_r <= sda_i;
    end

    // ==========================================================
    // pin synchronisers and bus conditions
    eep_pkg::eep_pins_t pins_raw;
    eep_pkg::eep_pins_t pins_s;
    logic scl_d_r;
    logic sda_d_r;
    logic rise_evt;
    logic fall_evt;
    logic start_evt;
    logic stop_evt;

    // an open select pin is pulled low at the pad, so it compares as zero
    assign pins_raw = '{scl: scl, sda: sda_i,
                        cs: {chip_select_bit_2, chip_select_bit_1, chip_select_bit_0},
                        wp: write_protect};

    eep_sync #(.WIDTH(6), .RESET_VAL(eep_pkg::PINS_RESET)) u_pin_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= pins_s.scl;
            sda_d_r <= pins_s.sda;
        end
    end

    // scl_bit_r is only read on a synchronised rise, long after it settled
    assign rise_evt = pins_s.scl & ~scl_d_r;
    assign fall_evt = ~pins_s.scl & scl_d_r;
    assign start_evt = pins_s.scl & scl_d_r & sda_d_r & ~pins_s.sda;
    assign stop_evt = pins_s.scl & scl_d_r & ~sda_d_r & pins_s.sda;

    // ==========================================================
    // helpers
    function automatic logic [eep_pkg::ADDR_W-1:0] page_inc(
        input logic [eep_pkg::ADDR_W-1:0] a);
        logic [eep_pkg::PAGE_OFS_W-1:0] ofs;
        ofs = a[eep_pkg::PAGE_OFS_W-1:0] + 1'b1;
        return {a[eep_pkg::ADDR_W-1:eep_pkg::PAGE_OFS_W], ofs};
    endfunction

    function automatic logic [eep_pkg::MEM_AW-1:0] mem_index(input logic id,
        input logic [eep_pkg::ADDR_W-1:0] a);
        if (id) begin
            return eep_pkg::ID_PAGE_BASE | eep_pkg::MEM_AW'(a[eep_pkg::PAGE_OFS_W-1:0]);
        end
        return {1'b0, a};
    endfunction

    // ==========================================================
    // state and byte-level decode
    eep_pkg::eep_state_t st_r;
    eep_pkg::eep_state_t st_nxt;
    logic [3:0] bit_cnt_r;
    logic ack_slot_r;
    logic [7:0] sh_r;
    logic [7:0] addr_hi_r;
    logic [eep_pkg::ADDR_W-1:0] addr_r;
    logic id_mode_r;
    logic lock_sel_r;
    logic lock_req_r;
    logic got_data_r;
    logic [eep_pkg::PAGE_BYTES-1:0] mask_r;
    logic rd_first_r;
    logic rd_pend_r;
    logic [7:0] tx_r;
    logic [WC_W-1:0] wc_cnt_r;
    logic commit_en_r;
    logic lock_pend_r;
    logic cm_v_r;
    logic [eep_pkg::PAGE_OFS_W-1:0] cm_idx_r;
    logic id_locked_r;
    logic busy_r;
    logic standby_r;
    logic sda_oe_n_r;
    logic sda_o_r;

    logic byte_end;
    logic slot_end;
    logic dev_match;
    logic dev_is_id;
    logic wr_refuse;
    logic give_ack;
    logic buf_we;
    logic rd_issue;
    logic rd_nack;
    logic commit_ok;
    logic stop_commit;
    logic wc_done;
    logic cm_rd;
    logic [7:0] buf_rdata;
    logic [7:0] mem_rdata;

    assign byte_end = fall_evt & (bit_cnt_r == eep_pkg::ACK_SLOT) & ~ack_slot_r;
    assign slot_end = fall_evt & ack_slot_r;
    assign dev_is_id = sh_r[eep_pkg::DEVADDR_TYPE_LSB +: 4] == eep_pkg::TYPE_ID_PAGE;
    assign dev_match = (dev_is_id
                        | (sh_r[eep_pkg::DEVADDR_TYPE_LSB +: 4] == eep_pkg::TYPE_ARRAY))
                       & (sh_r[eep_pkg::DEVADDR_CS_LSB +: 3] == pins_s.cs);
    assign wr_refuse = id_mode_r & ~lock_sel_r & id_locked_r;
    assign give_ack = ((st_r == eep_pkg::ST_DEVADDR) & dev_match)
                      | (st_r == eep_pkg::ST_ADDR_HI) | (st_r == eep_pkg::ST_ADDR_LO)
                      | ((st_r == eep_pkg::ST_WDATA) & ~wr_refuse);
    assign buf_we = byte_end & (st_r == eep_pkg::ST_WDATA) & ~wr_refuse;
    assign rd_issue = rise_evt & (st_r == eep_pkg::ST_RDATA) & ~ack_slot_r
                      & (bit_cnt_r == eep_pkg::ACK_SLOT) & (rd_first_r | ~scl_bit_r);
    assign rd_nack = rise_evt & (st_r == eep_pkg::ST_RDATA) & ~ack_slot_r
                     & (bit_cnt_r == eep_pkg::ACK_SLOT) & ~rd_first_r & scl_bit_r;
    // write-protect stops the write cycle, not the acknowledges; a locked id page stops both
    assign commit_ok = id_mode_r ? (lock_sel_r ? lock_req_r : ~id_locked_r)
                                 : ~pins_s.wp;
    assign stop_commit = (st_r == eep_pkg::ST_WDATA) & got_data_r & commit_ok;
    assign wc_done = (st_r == eep_pkg::ST_WCYCLE) & (wc_cnt_r == WC_W'(T_WR_CYC - 1));

    // ==========================================================
    // protocol state machine
    always_comb begin
        st_nxt = st_r;
        if (st_r == eep_pkg::ST_WCYCLE) begin
            if (wc_done) begin
                st_nxt = eep_pkg::ST_IDLE;
            end
        end else if (start_evt) begin
            st_nxt = eep_pkg::ST_DEVADDR;
        end else if (stop_evt) begin
            st_nxt = stop_commit ? eep_pkg::ST_WCYCLE : eep_pkg::ST_IDLE;
        end else if (byte_end) begin
            unique case (st_r)
                eep_pkg::ST_DEVADDR: begin
                    if (!dev_match) begin
                        st_nxt = eep_pkg::ST_IDLE;
                    end else if (sh_r[eep_pkg::DEVADDR_RW_BIT]) begin
                        st_nxt = eep_pkg::ST_RDATA;
                    end else begin
                        st_nxt = eep_pkg::ST_ADDR_HI;
                    end
                end
                eep_pkg::ST_ADDR_HI: st_nxt = eep_pkg::ST_ADDR_LO;
                eep_pkg::ST_ADDR_LO: st_nxt = eep_pkg::ST_WDATA;
                eep_pkg::ST_IDLE, eep_pkg::ST_WDATA, eep_pkg::ST_RDATA,
                eep_pkg::ST_WCYCLE: st_nxt = st_r;
            endcase
        end else if (rd_nack) begin
            st_nxt = eep_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= eep_pkg::ST_IDLE;
            busy_r <= 1'b0;
            standby_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            busy_r <= st_nxt == eep_pkg::ST_WCYCLE;
            standby_r <= st_nxt == eep_pkg::ST_IDLE;
        end
    end

    // ==========================================================
    // bit counter and receive shifter
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bit_cnt_r <= 4'h0;
            ack_slot_r <= 1'b0;
            sh_r <= 8'h00;
        end else if (start_evt || stop_evt) begin
            bit_cnt_r <= 4'h0;
            ack_slot_r <= 1'b0;
        end else if (rise_evt) begin
            if (bit_cnt_r != eep_pkg::ACK_SLOT) begin
                sh_r <= {sh_r[6:0], scl_bit_r};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end else begin
                ack_slot_r <= 1'b1;
            end
        end else if (slot_end) begin
            bit_cnt_r <= 4'h0;
            ack_slot_r <= 1'b0;
        end
    end

    // ==========================================================
    // address counter and command mode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_hi_r <= 8'h00;
            addr_r <= '0;
            id_mode_r <= 1'b0;
            lock_sel_r <= 1'b0;
        end else if (byte_end && st_r == eep_pkg::ST_DEVADDR && dev_match) begin
            id_mode_r <= dev_is_id;
        end else if (byte_end && st_r == eep_pkg::ST_ADDR_HI) begin
            addr_hi_r <= sh_r;
        end else if (byte_end && st_r == eep_pkg::ST_ADDR_LO) begin
            addr_r <= {addr_hi_r[eep_pkg::ADDR_W-9:0], sh_r};
            lock_sel_r <= addr_hi_r[eep_pkg::ID_LOCK_SEL_BIT-8];
        end else if (buf_we) begin
            addr_r <= page_inc(addr_r);
        end else if (rd_issue) begin
            // array reads roll over the whole array, id reads stay in the page
            addr_r <= id_mode_r ? page_inc(addr_r) : addr_r + 1'b1;
        end
    end

    // ==========================================================
    // page buffer fill; bytes reach the array only after the stop
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            got_data_r <= 1'b0;
            lock_req_r <= 1'b0;
            mask_r <= '0;
        end else if (byte_end && st_r == eep_pkg::ST_ADDR_LO) begin
            got_data_r <= 1'b0;
            lock_req_r <= 1'b0;
            mask_r <= '0;
        end else if (buf_we) begin
            got_data_r <= 1'b1;
            lock_req_r <= sh_r[eep_pkg::ID_LOCK_DATA_BIT];
            mask_r[addr_r[eep_pkg::PAGE_OFS_W-1:0]] <= 1'b1;
        end
    end

    eep_mem #(.DEPTH(eep_pkg::PAGE_BYTES), .AW(eep_pkg::PAGE_OFS_W), .DW(8)) u_page_buf (
        .clk_sys(clk_sys),
        .we(buf_we),
        .waddr(addr_r[eep_pkg::PAGE_OFS_W-1:0]),
        .wdata(sh_r),
        .re(cm_rd),
        .raddr(wc_cnt_r[eep_pkg::PAGE_OFS_W-1:0]),
        .rdata(buf_rdata)
    );

    // ==========================================================
    // internal write cycle: commit masked bytes, then time out
    assign cm_rd = busy_r & commit_en_r & (wc_cnt_r < WC_W'(eep_pkg::PAGE_BYTES));

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wc_cnt_r <= '0;
            commit_en_r <= 1'b0;
            lock_pend_r <= 1'b0;
            cm_v_r <= 1'b0;
            cm_idx_r <= '0;
        end else if (st_r != eep_pkg::ST_WCYCLE && st_nxt == eep_pkg::ST_WCYCLE) begin
            wc_cnt_r <= '0;
            commit_en_r <= ~(id_mode_r & lock_sel_r);
            lock_pend_r <= id_mode_r & lock_sel_r;
            cm_v_r <= 1'b0;
        end else begin
            if (st_r == eep_pkg::ST_WCYCLE) begin
                wc_cnt_r <= wc_cnt_r + 1'b1;
            end
            cm_v_r <= cm_rd;
            cm_idx_r <= wc_cnt_r[eep_pkg::PAGE_OFS_W-1:0];
        end
    end

    // lock is volatile here: it clears with rst_n
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            id_locked_r <= 1'b0;
        end else if (wc_done && lock_pend_r) begin
            id_locked_r <= 1'b1;
        end
    end

    eep_mem #(.DEPTH(eep_pkg::MEM_DEPTH), .AW(eep_pkg::MEM_AW), .DW(8)) u_array (
        .clk_sys(clk_sys),
        .we(cm_v_r & mask_r[cm_idx_r]),
        .waddr(mem_index(id_mode_r,
                         {addr_r[eep_pkg::ADDR_W-1:eep_pkg::PAGE_OFS_W], cm_idx_r})),
        .wdata(buf_rdata),
        .re(rd_issue),
        .raddr(mem_index(id_mode_r, addr_r)),
        .rdata(mem_rdata)
    );

    // ==========================================================
    // read data fetch
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_first_r <= 1'b0;
            rd_pend_r <= 1'b0;
            tx_r <= 8'hFF;
        end else begin
            rd_pend_r <= rd_issue;
            if (byte_end && st_r == eep_pkg::ST_DEVADDR) begin
                rd_first_r <= 1'b1;
            end else if (rd_issue) begin
                rd_first_r <= 1'b0;
            end
            if (rd_pend_r) begin
                tx_r <= mem_rdata;
            end
        end
    end

    // ==========================================================
    // data line driver: low or released, changed after a fall, released on a start or stop
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sda_oe_n_r <= 1'b1;
            sda_o_r <= 1'b0;
        end else if (st_r == eep_pkg::ST_WCYCLE || start_evt || stop_evt) begin
            sda_oe_n_r <= 1'b1;
        end else if (byte_end) begin
            sda_oe_n_r <= ~give_ack;
        end else if (slot_end) begin
            sda_oe_n_r <= (st_r == eep_pkg::ST_RDATA) ? tx_r[7] : 1'b1;
        end else if (fall_evt && st_r == eep_pkg::ST_RDATA && !ack_slot_r) begin
            sda_oe_n_r <= tx_r[3'd7 - bit_cnt_r[2:0]];
        end
    end

    assign sda_o = sda_o_r;
    assign sda_oe_n = sda_oe_n_r;
    assign busy = busy_r;
    assign standby = standby_r;
    assign id_page_locked = id_locked_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_addr_done;
        byte_end && st_r == eep_pkg::ST_DEVADDR;
    endsequence

    sequence s_commit_stop;
        stop_evt && st_r == eep_pkg::ST_WDATA && stop_commit;
    endsequence

    a_ack_on_match: assert property (
        s_addr_done and dev_match |=> !sda_oe_n_r)
        else $error("matching address not acknowledged");
    a_nack_mismatch: assert property (
        s_addr_done and !dev_match |=> sda_oe_n_r && st_r == eep_pkg::ST_IDLE)
        else $error("mismatching address acknowledged");
    a_busy_silent: assert property (
        busy_r |-> sda_oe_n_r)
        else $error("line driven during write cycle");
    a_cycle_holds: assert property (
        s_commit_stop |=> busy_r [*8])
        else $error("write cycle did not start or ended early");
    a_wp_blocks: assert property (
        stop_evt && st_r == eep_pkg::ST_WDATA && !id_mode_r && pins_s.wp |=> !busy_r)
        else $error("protected array entered a write cycle");
    a_page_kept: assert property (
        buf_we |=> addr_r[eep_pkg::ADDR_W-1:eep_pkg::PAGE_OFS_W]
                   == $past(addr_r[eep_pkg::ADDR_W-1:eep_pkg::PAGE_OFS_W]))
        else $error("page bits moved during page write");
    a_locked_nack: assert property (
        byte_end && st_r == eep_pkg::ST_WDATA && wr_refuse |=> sda_oe_n_r ##1 !busy_r)
        else $error("locked id page byte acknowledged");
    a_change_low: assert property (
        $changed(sda_oe_n_r) && !$past(start_evt) && !$past(stop_evt) |-> !$past(pins_s.scl))
        else $error("data line changed while clock high");
    a_start_restart: assert property (
        start_evt && st_r != eep_pkg::ST_WCYCLE |=> st_r == eep_pkg::ST_DEVADDR
                                                   && bit_cnt_r == 4'h0)
        else $error("start did not restart address phase");
    a_read_stop: assert property (
        stop_evt && (st_r == eep_pkg::ST_RDATA || st_r == eep_pkg::ST_IDLE) |=> standby_r)
        else $error("stop after read left standby off");
    a_low_only: assert property (
        !sda_oe_n_r |-> !sda_o_r
                        && (bit_cnt_r == eep_pkg::ACK_SLOT || st_r == eep_pkg::ST_RDATA))
        else $error("data line driven outside an acknowledge or read");
    a_cycle_ends: assert property (
        wc_done |=> standby_r && !busy_r)
        else $error("write cycle did not end in standby");

endmodule

// ==== verification/eep_master.sv ====
module eep_master (
    // link lines
    output logic scl,
    output logic sda,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // idle: both lines released, clock stands still between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // also serves as a repeated start, entered with the clock low
    task automatic start();
        #43 sda = 1'b1;
        #40 scl = 1'b1;
        #80 sda = 1'b0;
        #80 scl = 1'b0;
    endtask
    // hung bus: clock until the line reads high, at most nine times, then start
    task automatic recover();
        logic r;
        r = 1'b0;
        for (int i = 0; i < 9 && !r; i++) bit_x(1'b1, r);
        start();
    endtask
    task automatic stop();
        #40 sda = 1'b0;
        #40 scl = 1'b1;
        #80 sda = 1'b1;
        #80;
    endtask
    // data moves only with the clock low; sampled in the middle of the high phase
    task automatic bit_x(input logic b, output logic r);
        #40 sda = b;
        #40 scl = 1'b1;
        #40 r = sda_line;
        #40 scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, ack);
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(nack, r);
    endtask
endmodule

// ==== verification/tb_eep_top.sv ====
module tb_eep_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] cs_pin = 3'h5;
    logic wp = 1'b0;
    logic scl, sda_m, sda_o, sda_oe_n, busy, standby, locked;
    // open-drain wire with pull-up
    wire logic sda_line = sda_m & (sda_oe_n | sda_o);
    int failures = 0;
    int cmp_count = 0;
    logic [7:0] rb [0:31];
    always #5 clk_sys = ~clk_sys;
    eep_top #(.T_WR_CYC(200)) i_eep_top (.clk_sys(clk_sys), .rst_n(rst_n), .scl(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .chip_select_bit_2(cs_pin[2]),
        .chip_select_bit_1(cs_pin[1]), .chip_select_bit_0(cs_pin[0]), .write_protect(wp),
        .busy(busy), .standby(standby), .id_page_locked(locked));
    eep_master i_eep_master (.scl(scl), .sda(sda_m), .sda_line(sda_line));
    // ==========================================================
    // helpers
    function automatic logic [7:0] pat(input int i);
        return 8'h40 + 8'(i);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        i_eep_master.wbyte(b, a);
        chk({7'h00, a}, {7'h00, exp_ack});
    endtask
    task automatic wr(input logic [3:0] ty, input logic [15:0] a, input int n, input logic dk);
        i_eep_master.start();
        send({ty, 3'h5, 1'b0}, 1'b0);
        send(a[15:8], 1'b0);
        send(a[7:0], 1'b0);
        for (int i = 0; i < n; i++) send(pat(i), dk);
    endtask
    task automatic rd(input logic [3:0] ty, input logic [15:0] a, input int n);
        wr(ty, a, 0, 1'b0);
        i_eep_master.start();
        send({ty, 3'h5, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) i_eep_master.rbyte(i == n - 1, rb[i]);
        i_eep_master.stop();
    endtask
    // bounded wait for the write cycle to end
    task automatic settle();
        int k = 0;
        while (busy !== 1'b0 && k < 400) begin
            @(posedge clk_sys);
            k++;
        end
        if (busy !== 1'b0) begin
            failures++;
            end_sim();
        end else begin
            repeat (5) @(posedge clk_sys);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk({4'h0, sda_oe_n, busy, standby, locked}, 8'h0A);
        i_eep_master.recover();
        send({4'hA, 3'h4, 1'b0}, 1'b1);
        i_eep_master.stop();
        chk({7'h00, standby}, 8'h01);
        // 34 bytes from offset 30 wrap and overwrite the first two
        wr(4'hA, 16'h013E, 34, 1'b0);
        i_eep_master.stop();
        chk({6'h00, busy, standby}, 8'h02);
        i_eep_master.start();
        send({4'hA, 3'h5, 1'b0}, 1'b1);
        i_eep_master.stop();
        settle();
        i_eep_master.start();
        send({4'hA, 3'h5, 1'b1}, 1'b0);
        i_eep_master.rbyte(1'b1, rb[0]);
        i_eep_master.stop();
        chk(rb[0], pat(2));
        rd(4'hA, 16'h0120, 32);
        for (int i = 0; i < 32; i++) chk(rb[i], pat(i + 2));
        chk({7'h00, standby}, 8'h01);
        @(posedge clk_sys) wp <= 1'b1;
        wr(4'hA, 16'h0120, 1, 1'b0);
        i_eep_master.stop();
        repeat (20) @(posedge clk_sys);
        chk({7'h00, busy}, 8'h00);
        wp <= 1'b0;
        rd(4'hA, 16'h0120, 1);
        chk(rb[0], pat(2));
        wr(4'hB, 16'hF805, 2, 1'b0);
        i_eep_master.stop();
        settle();
        wr(4'hB, 16'h0400, 0, 1'b0);
        send(8'h02, 1'b0);
        i_eep_master.stop();
        settle();
        chk({7'h00, locked}, 8'h01);
        wr(4'hB, 16'h0005, 1, 1'b1);
        i_eep_master.stop();
        settle();
        rd(4'hB, 16'h0005, 2);
        chk(rb[0], pat(0));
        chk(rb[1], pat(1));
        end_sim();
    end
endmodule
